// ===== logic/vectored_irq_unit.sv
`timescale 1ns/10ps
`default_nettype none
`include "vic_params.svh"
module vectored_irq_unit (
  input wire logic sys_clk,
  input wire logic rst,
  input wire vic_pkg::vic_sources_t sources,
  input wire vic_pkg::vic_chans_t cfg_enable,
  input wire vic_pkg::vic_chans_t cfg_fast_select,
  input wire logic cfg_slot_we,
  input wire logic [`VIC_SLOT_W-1:0] cfg_slot_idx,
  input wire vic_pkg::vic_slot_cfg_t cfg_slot,
  input wire logic [`VIC_ADDR_W-1:0] cfg_default_addr,
  output logic fast_irq_out,
  output logic normal_irq_out,
  output vic_pkg::vic_chans_t fast_status,
  output vic_pkg::vic_chans_t normal_status,
  output vic_pkg::vic_chans_t raw_status,
  output logic [`VIC_ADDR_W-1:0] vector_addr
);
  // ************************************************************
  // Request sources gathered into channels.
  // ************************************************************
  // Peripheral flags are on-chip logic of this clock, so no synchroniser.
  // Each peripheral offers one line made by ORing its own flags, except the four external pins, which keep a channel each.
  vic_pkg::vic_chans_t chan_raw;
  wire [3:0] ext_pins;
  assign ext_pins = {sources.ext_pin_request_three,
                     sources.ext_pin_request_two,
                     sources.ext_pin_request_one,
                     sources.ext_pin_request_zero};
  assign chan_raw[`VIC_CH_WATCHDOG] = sources.watchdog_request;
  assign chan_raw[`VIC_CH_SOFT] = sources.soft_request;
  assign chan_raw[`VIC_CH_DBG_RX] = sources.debug_comm_receive;
  assign chan_raw[`VIC_CH_DBG_TX] = sources.debug_comm_transmit;
  assign chan_raw[`VIC_CH_TIMER0] = |sources.timer0_flags;
  assign chan_raw[`VIC_CH_TIMER1] = |sources.timer1_flags;
  assign chan_raw[`VIC_CH_UART0] = |sources.uart0_flags;
  assign chan_raw[`VIC_CH_UART1] = |sources.uart1_flags;
  assign chan_raw[`VIC_CH_PWM] = |sources.pwm_flags;
  assign chan_raw[`VIC_CH_I2C0] = sources.i2c0_state_flag;
  assign chan_raw[`VIC_CH_SPI] = sources.spi_transfer_done_flag |
                                 sources.spi_mode_fault_flag;
  assign chan_raw[`VIC_CH_SSP] = sources.tx_fifo_half_empty_flag |
                                 sources.rx_fifo_half_full_flag |
                                 sources.rx_timeout_flag |
                                 sources.rx_overrun_flag;
  assign chan_raw[`VIC_CH_PLL] = sources.pll_locked_flag;
  assign chan_raw[`VIC_CH_RTC] = sources.rtc_increment_flag |
                                 sources.rtc_alarm_flag;
  assign chan_raw[`VIC_CH_EXT0+3:`VIC_CH_EXT0] = ext_pins;
  assign chan_raw[`VIC_CH_ADC0] = sources.adc0_done;
  assign chan_raw[`VIC_CH_I2C1] = sources.i2c1_state_flag;
  assign chan_raw[`VIC_CH_BROWNOUT] = sources.brownout_flag;
  assign chan_raw[`VIC_CH_ADC1] = sources.adc1_done;
  assign chan_raw[`VIC_CH_USB] = |sources.usb_flags;

  // ************************************************************
  // Configuration registers.
  // ************************************************************
  vic_pkg::vic_chans_t enable_mask;
  vic_pkg::vic_chans_t fast_mask;
  logic [`VIC_NUM_SLOT-1:0] slot_en;
  logic [`VIC_CH_W-1:0] slot_chan [`VIC_NUM_SLOT];
  logic [`VIC_ADDR_W-1:0] default_addr;

  // Masks start cleared so no channel reaches either output after reset.
  // They are resampled every edge; software holds them as levels.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      enable_mask <= `VIC_RST_MASK;
      fast_mask <= `VIC_RST_MASK;
    end else begin
      enable_mask <= cfg_enable;
      fast_mask <= cfg_fast_select;
    end
  end

  // The default address resets to zero and then follows its input.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      default_addr <= `VIC_RST_ADDR;
    end else begin
      default_addr <= cfg_default_addr;
    end
  end

  // Slot enables reset cleared, which keeps every slot unassigned until
  // software writes it, whatever the table words happen to hold.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      slot_en <= '0;
    end else if (cfg_slot_we) begin
      slot_en[cfg_slot_idx] <= cfg_slot.enable;
    end
  end

  // Slot channel numbers; any channel may go to any slot.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < `VIC_NUM_SLOT; i++) begin
        slot_chan[i] <= '0;
      end
    end else if (cfg_slot_we) begin
      slot_chan[cfg_slot_idx] <= cfg_slot.channel;
    end
  end

  // ************************************************************
  // Classification.
  // ************************************************************
  wire [`VIC_NUM_CH-1:0] active;
  wire [`VIC_NUM_CH-1:0] fast_act;
  wire [`VIC_NUM_CH-1:0] norm_act;
  assign active = chan_raw & enable_mask;
  assign fast_act = active & fast_mask;
  assign norm_act = active & ~fast_mask;

  // A slot requests when enabled and its channel is an active normal one.
  // A fast channel also placed in a slot is served only as fast.
  wire [`VIC_NUM_SLOT-1:0] slot_req;
  genvar g;
  generate
    for (g = 0; g < `VIC_NUM_SLOT; g++) begin : g_slot
      assign slot_req[g] = slot_en[g] &&
                           chan_hit(norm_act, slot_chan[g]);
    end
  endgenerate

  // Channel numbers past the last channel never match.
  function automatic logic chan_hit(input logic [`VIC_NUM_CH-1:0] v,
                                    input logic [`VIC_CH_W-1:0] c);
    chan_hit = (c < `VIC_CH_W'(`VIC_NUM_CH)) ? v[c] : 1'b0;
  endfunction

  // Lowest-numbered requesting slot wins.
  function automatic logic [`VIC_SLOT_W-1:0] pick_slot(
      input logic [`VIC_NUM_SLOT-1:0] req);
    pick_slot = '0;
    for (int i = `VIC_NUM_SLOT - 1; i >= 0; i--) begin
      if (req[i]) begin
        pick_slot = `VIC_SLOT_W'(i);
      end
    end
  endfunction

  wire [`VIC_SLOT_W-1:0] win_slot;
  wire any_slot;
  assign win_slot = pick_slot(slot_req);
  assign any_slot = |slot_req;

  // ************************************************************
  // Vector address lookup.
  // ************************************************************
  // The table read register adds one cycle; the select is delayed to match.
  logic [`VIC_ADDR_W-1:0] table_addr;
  logic any_slot_q;
  vic_slot_table u_table (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(cfg_slot_we),
    .wr_slot(cfg_slot_idx),
    .wr_addr(cfg_slot.addr),
    .rd_slot(win_slot),
    .rd_addr(table_addr)
  );

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      any_slot_q <= 1'b0;
    end else begin
      any_slot_q <= any_slot;
    end
  end

  wire [`VIC_ADDR_W-1:0] next_vector_addr;
  assign next_vector_addr = any_slot_q ? table_addr : default_addr;

  // ************************************************************
  // Registered outputs.
  // ************************************************************
  // Fast and normal are independent lines, so fast outranking normal
  // is the core's job; non-vectored only loses the vector word.
  // Keeping the two lines apart lets the core take a fast request even
  // while it is inside a normal handler, which a shared line could not.
  wire next_fast_irq;
  wire next_normal_irq;
  assign next_fast_irq = |fast_act;
  assign next_normal_irq = |norm_act;

  // Request lines to the core.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fast_irq_out <= 1'b0;
      normal_irq_out <= 1'b0;
    end else begin
      fast_irq_out <= next_fast_irq;
      normal_irq_out <= next_normal_irq;
    end
  end

  // Status words share the cycle of the request lines, so a handler
  // reading them sees the same picture that raised its line.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fast_status <= `VIC_RST_MASK;
      normal_status <= `VIC_RST_MASK;
      raw_status <= `VIC_RST_MASK;
    end else begin
      fast_status <= fast_act;
      normal_status <= norm_act;
      raw_status <= chan_raw;
    end
  end

  // The vector word trails the request lines by one cycle because of the
  // table read register, so a handler must not read it in the very first
  // cycle of a new request.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      vector_addr <= `VIC_RST_ADDR;
    end else begin
      vector_addr <= next_vector_addr;
    end
  end
endmodule // vectored_irq_unit
`default_nettype wire

// ===== logic/vic_params.svh
`ifndef VIC_PARAMS_SVH
`define VIC_PARAMS_SVH
`define VIC_NUM_CH 23
`define VIC_CH_W 5
`define VIC_NUM_SLOT 16
`define VIC_SLOT_W 4
`define VIC_ADDR_W 32
`define VIC_CH_WATCHDOG 0
`define VIC_CH_SOFT 1
`define VIC_CH_DBG_RX 2
`define VIC_CH_DBG_TX 3
`define VIC_CH_TIMER0 4
`define VIC_CH_TIMER1 5
`define VIC_CH_UART0 6
`define VIC_CH_UART1 7
`define VIC_CH_PWM 8
`define VIC_CH_I2C0 9
`define VIC_CH_SPI 10
`define VIC_CH_SSP 11
`define VIC_CH_PLL 12
`define VIC_CH_RTC 13
`define VIC_CH_EXT0 14
`define VIC_CH_ADC0 18
`define VIC_CH_I2C1 19
`define VIC_CH_BROWNOUT 20
`define VIC_CH_ADC1 21
`define VIC_CH_USB 22
`define VIC_RST_MASK 23'h000000
`define VIC_RST_ADDR 32'h00000000
`endif

// ===== logic/vic_pkg.sv
`default_nettype none
`include "vic_params.svh"
package vic_pkg;
  typedef logic [`VIC_NUM_CH-1:0] vic_chans_t;
  // Configuration of one vectored slot.
  typedef struct packed {
    logic enable;
    logic [`VIC_CH_W-1:0] channel;
    logic [`VIC_ADDR_W-1:0] addr;
  } vic_slot_cfg_t;
  // Per-peripheral flags, each group combined into one channel; the four external pins keep one each.
  typedef struct packed {
    logic watchdog_request;
    logic soft_request;
    logic debug_comm_receive;
    logic debug_comm_transmit;
    logic [7:0] timer0_flags;
    logic [7:0] timer1_flags;
    logic [3:0] uart0_flags;
    logic [4:0] uart1_flags;
    logic [10:0] pwm_flags;
    logic i2c0_state_flag;
    logic spi_transfer_done_flag;
    logic spi_mode_fault_flag;
    logic tx_fifo_half_empty_flag;
    logic rx_fifo_half_full_flag;
    logic rx_timeout_flag;
    logic rx_overrun_flag;
    logic pll_locked_flag;
    logic rtc_increment_flag;
    logic rtc_alarm_flag;
    logic ext_pin_request_zero;
    logic ext_pin_request_one;
    logic ext_pin_request_two;
    logic ext_pin_request_three;
    logic adc0_done;
    logic i2c1_state_flag;
    logic brownout_flag;
    logic adc1_done;
    logic [2:0] usb_flags;
  } vic_sources_t;
endpackage
`default_nettype wire

// ===== logic/vic_slot_table.sv
`timescale 1ns/10ps
`default_nettype none
`include "vic_params.svh"
// Small table of slot routine addresses; read data leave a register.
module vic_slot_table (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [`VIC_SLOT_W-1:0] wr_slot,
  input wire logic [`VIC_ADDR_W-1:0] wr_addr,
  input wire logic [`VIC_SLOT_W-1:0] rd_slot,
  output logic [`VIC_ADDR_W-1:0] rd_addr
);
  logic [`VIC_ADDR_W-1:0] mem [`VIC_NUM_SLOT];

  // ************************************************************
  // Storage and registered read.
  // ************************************************************
  // Memory words carry no reset so they map to plain RAM.
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_slot] <= wr_addr;
    end
  end

  // Read register is reset so the vector output starts defined.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_addr <= `VIC_RST_ADDR;
    end else begin
      rd_addr <= mem[rd_slot];
    end
  end
endmodule // vic_slot_table
`default_nettype wire

// ===== testbench/vectored_irq_unit_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "vic_params.svh"
// ****************************************
// Self-checking bench
// ****************************************
module vectored_irq_unit_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  vic_pkg::vic_sources_t sources = '0;
  vic_pkg::vic_chans_t cfg_enable = '0;
  vic_pkg::vic_chans_t cfg_fast_select = '0;
  logic cfg_slot_we = 1'b0;
  logic [`VIC_SLOT_W-1:0] cfg_slot_idx = '0;
  vic_pkg::vic_slot_cfg_t cfg_slot = '0;
  logic [`VIC_ADDR_W-1:0] cfg_default_addr = 32'h00000100;
  logic fast_irq_out, normal_irq_out;
  vic_pkg::vic_chans_t fast_status, normal_status, raw_status;
  logic [`VIC_ADDR_W-1:0] vector_addr;
  logic [1:0] serving;
  int fails = 0;
  int tests_run = 0;
  // Lowest source bit of each channel, walking the packed flag groups.
  int lo[23] = '{60, 59, 58, 57, 49, 41, 37, 32, 21, 20, 18, 14, 13, 11, 10,
                 9, 8, 7, 6, 5, 4, 3, 0};
  vectored_irq_unit dut_u (.sys_clk, .rst, .sources, .cfg_enable,
    .cfg_fast_select, .cfg_slot_we, .cfg_slot_idx, .cfg_slot,
    .cfg_default_addr, .fast_irq_out, .normal_irq_out, .fast_status,
    .normal_status, .raw_status, .vector_addr);
  vic_core_model core_u (.sys_clk, .rst, .fast_irq_out, .normal_irq_out,
    .serving);
  // Free running system clock.
  always #2 sys_clk = ~sys_clk;
  task automatic check(input string what, input logic [31:0] got,
                       input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Inputs move on falling edges only, so no race with sampling.
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic put_slot(input logic [3:0] i, input logic [4:0] c,
                          input logic [31:0] a);
    cfg_slot_idx = i;
    cfg_slot = '{1'b1, c, a};
    cfg_slot_we = 1'b1;
    tick(1);
    cfg_slot_we = 1'b0;
    // Let an edge pass so a following call never re-raises the strobe
    // in the same time step in which it was lowered.
    tick(1);
  endtask
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic t_reset;
    sources = '1;
    tick(3);
    check("fast", fast_irq_out, 0);
    check("normal", normal_irq_out, 0);
    check("raw", raw_status, 32'h007fffff);
    $display("t_reset done");
  endtask
  // Every single flag must land on its own channel only.
  task automatic t_map;
    int ch;
    cfg_enable = '1;
    tick(4);
    for (int b = 0; b < 61; b++) begin
      sources = vic_pkg::vic_sources_t'(61'h1 << b);
      tick(2);
      ch = 0;
      while (lo[ch] > b) ch++;
      check("raw", raw_status, 32'h1 << ch);
      check("nstat", normal_status, 32'h1 << ch);
      check("nirq", normal_irq_out, 1);
    end
    $display("t_map done");
  endtask
  task automatic t_fast;
    cfg_fast_select = 23'h020001;
    tick(4);
    sources = (61'h1 << 60) | (61'h1 << 7) | 61'h1;
    tick(3);
    check("fast", fast_irq_out, 1);
    check("fstat", fast_status, 32'h00020001);
    check("nstat", normal_status, 32'h00400000);
    check("core", serving, 2'h2);
    sources = 61'h1;
    tick(3);
    check("fast", fast_irq_out, 0);
    check("core", serving, 2'h1);
    $display("t_fast done");
  endtask
  task automatic t_prio;
    cfg_fast_select = 23'h002000;
    put_slot(4'hf, 5'h04, 32'h0000a000);
    put_slot(4'h0, 5'h0d, 32'h0000b000);
    put_slot(4'h1, 5'h17, 32'h0000d000);
    sources = (61'h1 << 49) | (61'h1 << 11);
    tick(4);
    check("vector", vector_addr, 32'h0000a000);
    cfg_fast_select = '0;
    tick(4);
    check("vector", vector_addr, 32'h0000b000);
    sources = 61'h1 << 49;
    tick(3);
    check("vector", vector_addr, 32'h0000a000);
    sources = 61'h1 << 4;
    tick(3);
    check("vector", vector_addr, cfg_default_addr);
    check("nstat", normal_status, 32'h00100000);
    check("nirq", normal_irq_out, 1);
    // All lines quiet: the vector word falls back to the default.
    sources = '0;
    tick(3);
    check("vector", vector_addr, cfg_default_addr);
    check("nirq", normal_irq_out, 0);
    $display("t_prio done");
  endtask
  // A reset in mid-run must clear the slots while the masks reload.
  task automatic t_rerun;
    sources = 61'h1 << 49;
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(3);
    check("vector", vector_addr, cfg_default_addr);
    check("nirq", normal_irq_out, 1);
    $display("t_rerun done");
  endtask
  // Main sequence: six cycles of reset, then each scenario in turn.
  initial begin
    tick(6);
    rst = 1'b0;
    t_reset();
    t_map();
    t_fast();
    t_prio();
    t_rerun();
    complete_run();
  end
endmodule // vectored_irq_unit_tb
`default_nettype wire

// ===== testbench/vic_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "vic_params.svh"
// ****************************************
// Output checker for the interrupt unit
// ****************************************
module vic_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire vic_pkg::vic_sources_t sources,
  input wire vic_pkg::vic_chans_t cfg_enable,
  input wire vic_pkg::vic_chans_t cfg_fast_select,
  input wire logic [`VIC_ADDR_W-1:0] cfg_default_addr,
  input wire logic fast_irq_out,
  input wire logic normal_irq_out,
  input wire vic_pkg::vic_chans_t fast_status,
  input wire vic_pkg::vic_chans_t normal_status,
  input wire vic_pkg::vic_chans_t raw_status,
  input wire logic [`VIC_ADDR_W-1:0] vector_addr
);
  logic [1:0] calm;
  // Counts quiet configuration edges, since status lags configuration by two edges.
  always_ff @(posedge sys_clk) begin
    if (rst || !$stable(cfg_enable) || !$stable(cfg_fast_select) ||
        !$stable(cfg_default_addr)) begin
      calm <= 2'h0;
    end else if (calm != 2'h3) begin
      calm <= calm + 2'h1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Two quiet edges with no line raised leave no slot to win.
  sequence s_quiet;
    (calm == 2'h3 && raw_status == '0) [*2];
  endsequence
  a_fast_merge: assert property (fast_irq_out == |fast_status)
    else $error("fast output disagrees with fast status");
  a_normal_merge: assert property (normal_irq_out == |normal_status)
    else $error("normal output disagrees with normal status");
  a_class_apart: assert property ((fast_status & normal_status) == '0)
    else $error("channel reported in both classes");
  a_reset_quiet: assert property (disable iff (1'b0) rst |=>
    !fast_irq_out && !normal_irq_out && vector_addr == '0)
    else $error("outputs active after reset");
  a_fast_mask: assert property (calm == 2'h3 |-> fast_status ==
    (raw_status & $past(cfg_enable) & $past(cfg_fast_select)))
    else $error("fast status wrong for mask");
  a_normal_mask: assert property (calm == 2'h3 |-> normal_status ==
    (raw_status & $past(cfg_enable) & ~$past(cfg_fast_select)))
    else $error("normal status wrong for mask");
  a_vec_default: assert property (s_quiet |->
    vector_addr == $past(cfg_default_addr))
    else $error("vector not default while idle");
  a_chan_map: assert property (!$past(rst) |->
    raw_status[0] == $past(sources.watchdog_request) &&
    raw_status[17] == $past(sources.ext_pin_request_three))
    else $error("channel line misrouted");
endmodule // vic_checker
bind vectored_irq_unit vic_checker chk_u (.sys_clk, .rst, .sources,
  .cfg_enable, .cfg_fast_select, .cfg_default_addr, .fast_irq_out,
  .normal_irq_out, .fast_status, .normal_status, .raw_status, .vector_addr);
`default_nettype wire

// ===== testbench/vic_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Processor core interrupt entry model
// ****************************************
module vic_core_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic fast_irq_out,
  input wire logic normal_irq_out,
  output logic [1:0] serving
);
  // The core serves fast first; normal is taken only while fast is quiet.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      serving <= 2'h0;
    end else if (fast_irq_out) begin
      serving <= 2'h2;
    end else begin
      serving <= {1'b0, normal_irq_out};
    end
  end
endmodule // vic_core_model
`default_nettype wire
